//--- verilog/asrp_pkg.sv
// Constants for the serial result port of the 14-bit converter
// Contract
// (RQ1) Serial clock alone paces conversion and shifting
// (RQ2) Advance each bit on serial clock fall
// (RQ3) Two zeros, then 14 bits MSB first
// (RQ4) Four trailing zeros when select held 24 clocks
// (RQ5) Select low starts a new conversion
// (RQ6) Select low interval frames the data stream
// (RQ7) Return sampler to tracking after conversion
// (RQ8) Host waits 50 ns before reselecting
// (RQ9) Result coded straight binary, LSB full scale/16384
// (RQ10) Output high impedance while select is high
package asrp_pkg;
  // ==========================================================================
  // Frame layout
  localparam int RESULT_BITS = 14;
  localparam int LEAD_ZEROS = 2;
  localparam int FRAME_BITS = 16;
  localparam int LONG_FRAME_BITS = 24;
  localparam int TAIL_ZEROS = 4;
  localparam int CODE_STEPS = 16384;
  localparam logic [4:0] BIT_CNT_RST = 5'h00;
  localparam logic [4:0] TAIL_END = 5'h14;
  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int QUIET_NS = 50;
  localparam int QUIET_CYCLES = (QUIET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // ==========================================================================
  // Port states
  typedef enum logic [1:0] {
    ASRP_TRACK = 2'b00,
    ASRP_CONVERT = 2'b01,
    ASRP_TAIL = 2'b11,
    ASRP_DONE = 2'b10
  } asrp_state_t;
endpackage : asrp_pkg

//--- verilog/asrp_fifo.sv
// Small synchronous FIFO holding finished conversion codes
`timescale 1ns/1ps
module asrp_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
      $error("asrp_fifo: depth must be a power of two above one");
    end
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_ff;
  logic [AW:0] rdPtr_ff;
  logic [AW:0] used;
  logic [AW:0] fill_ff;
  logic [AW:0] nxt_fill;
  logic doWrite;
  logic doRead;
  assign used = wrPtr_ff - rdPtr_ff;
  assign doWrite = inValid && inReady;
  assign doRead = outReady && outValid;
  // Fill counts the read register as well, so at most DEPTH words are held
  assign nxt_fill = fill_ff + {{AW{1'b0}}, doWrite} - {{AW{1'b0}}, doRead};
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fill_ff <= '0;
      inReady <= 1'b1;
    end else begin
      fill_ff <= nxt_fill;
      inReady <= (nxt_fill != (AW+1)'(DEPTH));
    end
  end
  always_ff @(posedge ref_clk) begin
    if (doWrite) begin
      mem[wrPtr_ff[AW-1:0]] <= inData;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wrPtr_ff <= '0;
    end else if (doWrite) begin
      wrPtr_ff <= wrPtr_ff + 1'b1;
    end
  end
  // Read data sits in a register; valid follows the register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdPtr_ff <= '0;
      outValid <= 1'b0;
      outData <= '0;
    end else if (!outValid || outReady) begin
      if (used != '0) begin
        outData <= mem[rdPtr_ff[AW-1:0]];
        rdPtr_ff <= rdPtr_ff + 1'b1;
        outValid <= 1'b1;
      end else begin
        outValid <= 1'b0;
      end
    end
  end
endmodule : asrp_fifo

//--- verilog/asrp_port.sv
// Serial result port: select and serial clock in, result bits out
`timescale 1ns/1ps
module asrp_port
  import asrp_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic selectN,
  input wire logic serialClk,
  input wire logic [RESULT_BITS-1:0] analogInput,
  input wire logic codeValid,
  output logic codeReady,
  output logic serialResultOut,
  output logic serialResultOutEn,
  output logic trackMode,
  output logic sampleStrobe
);
  initial begin
    if (FIFO_DEPTH < 2 || (1 << $clog2(FIFO_DEPTH)) != FIFO_DEPTH) begin
      $error("asrp_port: FIFO_DEPTH must be a power of two above one");
    end
    if (LEAD_ZEROS + RESULT_BITS != FRAME_BITS) begin
      $error("asrp_port: frame width does not match its parts");
    end
    if (int'(TAIL_END) != FRAME_BITS + TAIL_ZEROS) begin
      $error("asrp_port: tail end does not match the frame");
    end
  end
  // ==========================================================================
  // Pin synchronisers
  logic selMeta_ff, selSync_ff, selPrev_ff;
  logic clkMeta_ff, clkSync_ff, clkPrev_ff;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      selMeta_ff <= 1'b1;
      selSync_ff <= 1'b1;
      selPrev_ff <= 1'b1;
      clkMeta_ff <= 1'b1;
      clkSync_ff <= 1'b1;
      clkPrev_ff <= 1'b1;
    end else begin
      selMeta_ff <= selectN;
      selSync_ff <= selMeta_ff;
      selPrev_ff <= selSync_ff;
      clkMeta_ff <= serialClk;
      clkSync_ff <= clkMeta_ff;
      clkPrev_ff <= clkSync_ff;
    end
  end
  logic selFall, sclkFall, active;
  assign selFall = selPrev_ff && !selSync_ff;
  assign sclkFall = clkPrev_ff && !clkSync_ff; // [RQ1]
  assign active = !selSync_ff;
  // ==========================================================================
  // Sample capture: the FIFO feeds codes, one popped per select fall while it holds one
  logic fifoValid;
  logic [RESULT_BITS-1:0] fifoData;
  logic popCode;
  asrp_fifo #(
    .WIDTH(RESULT_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .inValid(codeValid),
    .inReady(codeReady),
    .inData(analogInput),
    .outValid(fifoValid),
    .outReady(popCode),
    .outData(fifoData)
  );
  assign popCode = selFall && fifoValid;
  // ==========================================================================
  // Frame state
  asrp_state_t state_ff;
  logic [4:0] bitCnt_ff;
  logic [FRAME_BITS-1:0] shift_ff;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff <= ASRP_TRACK;
      bitCnt_ff <= BIT_CNT_RST;
      shift_ff <= '0;
    end else if (!active) begin
      state_ff <= ASRP_TRACK; // [RQ6]
      bitCnt_ff <= BIT_CNT_RST;
    end else if (selFall) begin
      // Straight binary code, two zeros ahead of it [RQ3] [RQ5] [RQ9]
      state_ff <= ASRP_CONVERT;
      bitCnt_ff <= BIT_CNT_RST;
      shift_ff <= {{LEAD_ZEROS{1'b0}}, (fifoValid ? fifoData : '0)};
    end else if (sclkFall) begin
      case (state_ff)
        ASRP_CONVERT: begin
          shift_ff <= {shift_ff[FRAME_BITS-2:0], 1'b0}; // [RQ2]
          bitCnt_ff <= bitCnt_ff + 5'h01;
          if (bitCnt_ff == 5'(FRAME_BITS - 1)) begin
            state_ff <= ASRP_TAIL;
          end
        end
        ASRP_TAIL: begin
          shift_ff <= '0; // [RQ4]
          bitCnt_ff <= bitCnt_ff + 5'h01;
          if (bitCnt_ff == TAIL_END - 5'h01) begin
            state_ff <= ASRP_DONE;
          end
        end
        ASRP_TRACK, ASRP_DONE: begin
          state_ff <= state_ff;
        end
        default: begin
          state_ff <= ASRP_TRACK;
        end
      endcase
    end
  end
  // ==========================================================================
  // Outputs
  logic converting;
  logic nxt_serialResultOut;
  logic nxt_serialResultOutEn;
  logic nxt_trackMode;
  assign converting = active && (state_ff == ASRP_CONVERT);
  always_comb begin
    nxt_serialResultOut = converting && shift_ff[FRAME_BITS-1];
    nxt_serialResultOutEn = active && !selFall && (state_ff != ASRP_DONE); // [RQ10]
    nxt_trackMode = !(converting && !selFall); // [RQ7]
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      serialResultOut <= 1'b0;
      serialResultOutEn <= 1'b0;
    end else begin
      serialResultOut <= nxt_serialResultOut;
      serialResultOutEn <= nxt_serialResultOutEn;
    end
  end
  // Sampler tracks outside conversion, holds during it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      trackMode <= 1'b1;
      sampleStrobe <= 1'b0;
    end else begin
      trackMode <= nxt_trackMode;
      sampleStrobe <= selFall;
    end
  end
  // ==========================================================================
  // Copy of the code in flight, read only by the checks
  logic [RESULT_BITS-1:0] frameCode_ff;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      frameCode_ff <= '0;
    end else if (selFall) begin
      frameCode_ff <= fifoValid ? fifoData : '0;
    end
  end
  // ==========================================================================
  // Checks
  AST_ZERO_LEAD: assert property (@(posedge ref_clk) disable iff (rst) // [RQ3]
    (state_ff == ASRP_CONVERT && active && bitCnt_ff < 5'h02) |=> !serialResultOut)
    else $error("leading bit not zero");
  AST_TAIL_ZERO: assert property (@(posedge ref_clk) disable iff (rst) // [RQ4]
    (state_ff == ASRP_TAIL) |=> !serialResultOut)
    else $error("tail bit not zero");
  AST_HIZ_IDLE: assert property (@(posedge ref_clk) disable iff (rst) // [RQ10]
    selSync_ff |=> !serialResultOutEn)
    else $error("output driven while deselected");
  AST_START: assert property (@(posedge ref_clk) disable iff (rst) // [RQ5]
    selFall |=> state_ff == ASRP_CONVERT && bitCnt_ff == 5'h00)
    else $error("select fall did not start conversion");
  AST_FRAME: assert property (@(posedge ref_clk) disable iff (rst) // [RQ6]
    $rose(selSync_ff) |=> state_ff == ASRP_TRACK)
    else $error("frame not ended by select");
  AST_SHIFT_EDGE: assert property (@(posedge ref_clk) disable iff (rst) // [RQ2]
    (active && !selFall && !sclkFall && state_ff == ASRP_CONVERT) |=> $stable(shift_ff))
    else $error("shift without serial clock fall");
  AST_PACE: assert property (@(posedge ref_clk) disable iff (rst) // [RQ1]
    (active && !selFall && !sclkFall) |=> $stable(bitCnt_ff))
    else $error("count moved without serial clock");
  AST_TRACK: assert property (@(posedge ref_clk) disable iff (rst) // [RQ7]
    (state_ff == ASRP_TAIL) |=> trackMode)
    else $error("sampler not tracking after conversion");
  AST_COUNT: assert property (@(posedge ref_clk) disable iff (rst) // [RQ3]
    (state_ff == ASRP_CONVERT && sclkFall && active && !selFall && bitCnt_ff == 5'h0f)
    |=> state_ff == ASRP_TAIL)
    else $error("frame length wrong");
  // Bit order checked against the copy of the code in flight
  AST_DATA_BIT: assert property (@(posedge ref_clk) disable iff (rst) // [RQ3] [RQ9]
    (converting && bitCnt_ff >= 5'h02)
    |=> serialResultOut == $past(frameCode_ff[4'(5'h0f - bitCnt_ff)]))
    else $error("result bit out of order");
  AST_EN_RISE: assert property (@(posedge ref_clk) disable iff (rst) // [RQ6]
    (selFall ##1 active) |=> serialResultOutEn)
    else $error("output not driven inside the frame");
  AST_STROBE: assert property (@(posedge ref_clk) disable iff (rst) // [RQ5]
    sampleStrobe == $past(selFall))
    else $error("sample strobe does not follow select fall");
  AST_STEP: assert property (@(posedge ref_clk) disable iff (rst) // [RQ1]
    (converting && sclkFall && !selFall) |=> bitCnt_ff == $past(bitCnt_ff) + 5'h01)
    else $error("count did not step on serial clock fall");
  AST_TAIL_END: assert property (@(posedge ref_clk) disable iff (rst) // [RQ4]
    (active && state_ff == ASRP_TAIL && sclkFall && bitCnt_ff == TAIL_END - 5'h01)
    |=> state_ff == ASRP_DONE)
    else $error("tail longer or shorter than four bits");
  AST_DONE_QUIET: assert property (@(posedge ref_clk) disable iff (rst) // [RQ10]
    (active && state_ff == ASRP_DONE) |=> !serialResultOutEn)
    else $error("output still driven after the tail");
  AST_HOLD: assert property (@(posedge ref_clk) disable iff (rst) // [RQ7]
    (converting && !selFall) |=> !trackMode)
    else $error("sampler tracking during conversion");
  AST_EMPTY_ZERO: assert property (@(posedge ref_clk) disable iff (rst) // [RQ9]
    (selFall && !fifoValid) |=> shift_ff == '0)
    else $error("empty buffer did not give a zero code");
  AST_IDLE_LOW: assert property (@(posedge ref_clk) disable iff (rst) // [RQ10]
    !active |=> !serialResultOut)
    else $error("data bit driven while deselected");
  COV_FRAME: cover property (@(posedge ref_clk) disable iff (rst) state_ff == ASRP_TAIL);
  COV_LONG: cover property (@(posedge ref_clk) disable iff (rst) state_ff == ASRP_DONE);
  COV_POP: cover property (@(posedge ref_clk) disable iff (rst) popCode);
  COV_FULL: cover property (@(posedge ref_clk) disable iff (rst) !codeReady);
  COV_ABORT: cover property (@(posedge ref_clk) disable iff (rst)
    $rose(selSync_ff) && state_ff == ASRP_CONVERT);
endmodule : asrp_port

//--- testbench/asrp_host_model.sv
// Host serial master model: frames with select, clocks bits in
`timescale 1ns/1ps
module asrp_host_model (
  input wire logic dataOut,
  input wire logic dataEn,
  output logic selectN,
  output logic serialClk
);
  initial begin
    selectN = 1'b1;
    serialClk = 1'b1;
  end
  // ==========================================================================
  // One frame of n serial clocks, 125 ns period
  task automatic frame(input int n, output logic [23:0] bits, output int enCnt);
    bits = 24'h000000;
    enCnt = 0;
    selectN <= 1'b0;
    #62.5;
    for (int i = 0; i < n; i++) begin
      // Sample between falling edges; released line reads inverted
      bits = {bits[22:0], (dataEn === 1'b1) ? dataOut : ~dataOut};
      if (dataEn === 1'b1) enCnt++;
      #0 serialClk <= 1'b0;
      #62.5 serialClk <= 1'b1;
      #62.5;
    end
    selectN <= 1'b1;
    // Line lets go a few clocks after select rises; quiet time counts from there
    #100;
  endtask : frame
endmodule : asrp_host_model

//--- testbench/adc_serial_result_port_bench.sv
// Bench for the serial result port driven by a host model
`timescale 1ns/1ps
module adc_serial_result_port_bench;
  import asrp_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic codeValid = 1'b0;
  logic [RESULT_BITS-1:0] analogInput = 14'h0000;
  logic selectN, serialClk, codeReady, dataOut, dataEn, trackMode, sampleStrobe;
  logic [23:0] bits;
  logic [13:0] c;
  int enCnt;
  int fails = 0;
  int compares = 0;
  int strobes = 0;
  int holdCycles = 0;
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (sampleStrobe === 1'b1) strobes++;
  always @(posedge ref_clk) if (trackMode === 1'b0) holdCycles++;
  asrp_port asrp_port_inst (.ref_clk(ref_clk), .rst(rst), .selectN(selectN),
    .serialClk(serialClk), .analogInput(analogInput), .codeValid(codeValid),
    .codeReady(codeReady), .serialResultOut(dataOut), .serialResultOutEn(dataEn),
    .trackMode(trackMode), .sampleStrobe(sampleStrobe));
  asrp_host_model asrp_host_model_inst (.dataOut(dataOut), .dataEn(dataEn),
    .selectN(selectN), .serialClk(serialClk));
  // ==========================================================================
  // Helpers
  function automatic logic [13:0] codeOf(input int i);
    return 14'h3fff - 14'(i) * 14'h0411;
  endfunction : codeOf
  task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  task automatic print_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  // ==========================================================================
  // Scenarios
  task automatic test_reset;
    repeat (4) @(posedge ref_clk);
    #1;
    check({20'h0, trackMode, dataEn, codeReady, sampleStrobe}, 24'h00000a, "idle");
    $display("test reset done");
  endtask : test_reset
  task automatic test_fill;
    int n;
    n = 0;
    @(posedge ref_clk);
    codeValid <= 1'b1;
    analogInput <= codeOf(0);
    repeat (24) begin
      @(posedge ref_clk);
      if (codeReady === 1'b1) n++;
      analogInput <= codeOf(n);
    end
    codeValid <= 1'b0;
    #1;
    check(24'(n), 24'd16, "accepted");
    check({23'h0, codeReady}, 24'h0, "full");
    $display("test fill done");
  endtask : test_fill
  task automatic test_long;
    int h;
    h = holdCycles;
    asrp_host_model_inst.frame(24, bits, enCnt);
    check({4'h0, bits[23:4]}, {6'h00, codeOf(0), 4'h0}, "long");
    check(24'(enCnt), 24'd20, "long en");
    check({23'h0, trackMode}, 24'h1, "track");
    // Hold spans select fall to the 16th clock fall, 1937.5 ns, give or take sync
    check(24'((holdCycles - h >= 384) && (holdCycles - h <= 391)), 24'h1, "hold");
    $display("test long done");
  endtask : test_long
  task automatic test_abort;
    c = codeOf(1);
    asrp_host_model_inst.frame(8, bits, enCnt);
    check({16'h0, bits[7:0]}, {18'h0, c[13:8]}, "abort");
    repeat (10) @(posedge ref_clk);
    #1;
    check({23'h0, dataEn}, 24'h0, "released");
    $display("test abort done");
  endtask : test_abort
  task automatic test_drain;
    for (int i = 2; i < 16; i++) begin
      asrp_host_model_inst.frame(16, bits, enCnt);
      check({8'h0, bits[15:0]}, {10'h0, codeOf(i)}, "code");
      check(24'(enCnt), 24'd16, "short en");
    end
    asrp_host_model_inst.frame(16, bits, enCnt);
    check(bits, 24'h0, "empty");
    check(24'(strobes), 24'd17, "starts");
    check({23'h0, codeReady}, 24'h1, "drained");
    $display("test drain done");
  endtask : test_drain
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    test_reset;
    test_fill;
    test_long;
    test_abort;
    test_drain;
    print_verdict;
  end
endmodule : adc_serial_result_port_bench
